// File: verilog/twras_slave.sv
// Purpose: target-side two-wire transaction engine with pointer auto-increment
// Assumes: register storage sits outside; read data follows rd_addr_out combinationally
// Notes: writes leave as whole sixteen-bit words only
//
// Behaviour
// - write: address, pointer, two or more bytes
// - first data byte lands at pointer
// - in writes, device drives data only during acknowledge
// - device drives from read address acknowledge on
// - master not-acknowledge hands line back
// - first data bit right after pointer acknowledge
// - pointer steps after each written byte
// - writes beyond 4Fh are discarded
// - only complete sixteen-bit writes take effect
// - writes to read-only locations are dropped
// - partial or unacknowledged bytes never stored
// - first read byte from pointer, MSB first
// - pointer steps after each returned byte
// - reads beyond FFh return FFh
// - reserved locations return undefined data
// - respond only to fixed target address
// - eight bits MSB first, then acknowledge
// - register MSB at even, LSB odd
`timescale 1ns/1ps
module twras_slave #(
   parameter logic [6:0] TARGET_ADDR = twras_pkg::TGT_ADDR,
   parameter logic [39:0] WRITABLE_PAIRS = twras_pkg::WRITABLE_DEF
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n_out,
   output logic [7:0] rd_addr_out,
   input wire logic [7:0] rd_data_in,
   output logic wr_valid_out,
   output logic [7:0] wr_addr_out,
   output logic [15:0] wr_data_out
);
   import twras_pkg::*;

   // general call address cannot be served as a fixed target
   if (TARGET_ADDR == 7'h00) begin : g_bad_addr
      $error("target address zero is not allowed");
   end

   twras_bus_if ev ();
   twras_state_s q, n;
   logic load;
   logic [7:0] next_byte;
   logic [8:0] ptr_next;

   twras_line_sync u_sync (
      .clock_in(clock_in),
      .rstn_in(rstn_in),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .ev(ev)
   );

   // saturating pointer step and outgoing byte choice
   always_comb begin
      // saturation keeps a long read on the fill byte
      ptr_next = q.ptr[8] ? PTR_SAT : q.ptr + PTR_STEP;
      next_byte = q.ptr[8] ? FILL_BYTE : rd_data_in;
   end

   // transaction engine: samples on clock rise, drives on clock fall
   always_comb begin
      n = q;
      load = 1'b0;
      n.wr_valid = 1'b0;
      if (ev.stop) begin
         n.fsm = S_IDLE;
         n.oe_n = 1'b1;
         n.msb_ok = 1'b0;
      end else if (ev.start) begin
         // a restart also drops a half-written register
         n.fsm = S_ADDR;
         n.bitcnt = CNT_ZERO;
         n.oe_n = 1'b1;
         n.msb_ok = 1'b0;
      end else if (ev.scl_rise) begin
         case (q.fsm)
            S_ADDR, S_PTR, S_WDATA: begin
               if (q.bitcnt != BYTE_BITS) begin
                  n.shift = {q.shift[6:0], ev.sda};
                  n.bitcnt = q.bitcnt + CNT_ONE;
                  if (q.fsm == S_WDATA && q.bitcnt == BYTE_BITS - CNT_ONE) begin
                     n.pend_addr = q.ptr;
                     n.ptr = ptr_next;
                  end
               end
            end
            S_RACK: begin
               if (ev.sda) begin
                  n.fsm = S_IDLE;
                  n.oe_n = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end else if (ev.scl_fall) begin
         case (q.fsm)
            S_ADDR: begin
               if (q.bitcnt == BYTE_BITS) begin
                  if (q.shift[7:1] == TARGET_ADDR) begin
                     n.fsm = S_AACK;
                     n.oe_n = 1'b0;
                     n.rd_dir = q.shift[0];
                  end else begin
                     n.fsm = S_IDLE;
                     n.oe_n = 1'b1;
                  end
               end
            end
            S_AACK, S_RACK: begin
               if (q.fsm == S_RACK || q.rd_dir) begin
                  load = 1'b1;
                  n.oe_n = next_byte[7];
                  n.shift = {next_byte[6:0], 1'b0};
                  n.bitcnt = CNT_ONE;
                  n.fsm = S_RDATA;
               end else begin
                  n.oe_n = 1'b1;
                  n.bitcnt = CNT_ZERO;
                  n.fsm = S_PTR;
               end
            end
            S_RDATA: begin
               if (q.bitcnt == BYTE_BITS) begin
                  n.ptr = ptr_next;
                  n.oe_n = 1'b1;
                  n.fsm = S_RACK;
               end else begin
                  n.oe_n = q.shift[7];
                  n.shift = {q.shift[6:0], 1'b0};
                  n.bitcnt = q.bitcnt + CNT_ONE;
               end
            end
            S_PTR: begin
               if (q.bitcnt == BYTE_BITS) begin
                  n.ptr = {1'b0, q.shift};
                  n.oe_n = 1'b0;
                  n.fsm = S_PACK;
               end
            end
            S_WDATA: begin
               if (q.bitcnt == BYTE_BITS) begin
                  n.oe_n = 1'b0;
                  n.fsm = S_WACK;
               end
            end
            S_PACK, S_WACK: begin
               n.oe_n = 1'b1;
               n.bitcnt = CNT_ZERO;
               n.fsm = S_WDATA;
               if (q.fsm == S_WACK) begin
                  if (q.pend_addr > WR_TOP) begin
                     n.msb_ok = 1'b0;
                  end else if (!q.pend_addr[0]) begin
                     n.msb_byte = q.shift;
                     n.msb_addr = q.pend_addr[7:0];
                     n.msb_ok = 1'b1;
                  end else begin
                     n.msb_ok = 1'b0;
                     if (q.msb_ok && q.msb_addr == {q.pend_addr[7:1], 1'b0}
                         && WRITABLE_PAIRS[q.pend_addr[6:1]]) begin
                        n.wr_valid = 1'b1;
                        n.wr_addr = q.msb_addr;
                        n.wr_data = {q.msb_byte, q.shift};
                     end
                  end
               end
            end
            default: begin
               n.oe_n = 1'b1;
            end
         endcase
      end
   end

   // state register; line released and pointer at zero after reset
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '{fsm: S_IDLE, oe_n: 1'b1, default: '0};
      end else begin
         q <= n;
      end
   end

   // open-drain data: only ever pulls low, enable low means driving
   always_comb begin
      sda_out = 1'b0;
      sda_oe_n_out = q.oe_n;
      rd_addr_out = q.ptr[7:0];
      wr_valid_out = q.wr_valid;
      wr_addr_out = q.wr_addr;
      wr_data_out = q.wr_data;
   end

   // guards on the engine; expectations follow the rules, not the next-state code
   a_write_even_addr: assert property (@(posedge clock_in) disable iff (!rstn_in)
      wr_valid_out |-> wr_addr_out[0] == 1'b0)
      else $error("word write at odd address");

   a_write_limit: assert property (@(posedge clock_in) disable iff (!rstn_in)
      wr_valid_out |-> {1'b0, wr_addr_out} < WR_TOP)
      else $error("word write beyond write limit");

   a_ro_dropped: assert property (@(posedge clock_in) disable iff (!rstn_in)
      wr_valid_out |-> WRITABLE_PAIRS[wr_addr_out[6:1]])
      else $error("write reached a read-only pair");

   a_commit_after_ack: assert property (@(posedge clock_in) disable iff (!rstn_in)
      $rose(wr_valid_out) |-> $past(q.fsm) == S_WACK && q.fsm == S_WDATA)
      else $error("word committed outside acknowledge end");

   a_write_quiet: assert property (@(posedge clock_in) disable iff (!rstn_in)
      q.fsm inside {S_WDATA, S_PTR} |-> sda_oe_n_out)
      else $error("device drove data during written byte");

   a_idle_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
      ev.stop |=> q.fsm == S_IDLE && sda_oe_n_out)
      else $error("stop did not release the line");

   a_nack_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (q.fsm == S_RACK && ev.scl_rise && ev.sda) |=> sda_oe_n_out [*3])
      else $error("line still driven after not-acknowledge");

   a_ptr_step: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (q.fsm == S_WDATA && ev.scl_rise && q.bitcnt == 4'h7 && !q.ptr[8] && !ev.start && !ev.stop)
      |=> q.ptr == $past(q.ptr) + 9'h001)
      else $error("pointer did not step after written byte");

   a_fill_top: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (load && q.ptr[8]) |=> sda_oe_n_out && q.shift == 8'hFE)
      else $error("read past top did not return all ones");

   a_read_msb: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (load && !q.ptr[8]) |=> sda_oe_n_out == $past(rd_data_in[7]) && q.fsm == S_RDATA)
      else $error("first read bit is not the pointed MSB");

   a_addr_match: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (q.fsm == S_AACK && $past(q.fsm) == S_ADDR)
      |-> q.shift[7:1] == TARGET_ADDR)
      else $error("acknowledged a foreign address");

   a_read_release: assert property (@(posedge clock_in) disable iff (!rstn_in)
      q.fsm == S_RACK |-> sda_oe_n_out)
      else $error("line driven during master acknowledge");

   a_ack_drive: assert property (@(posedge clock_in) disable iff (!rstn_in)
      q.fsm inside {S_AACK, S_PACK, S_WACK} |-> !sda_oe_n_out)
      else $error("acknowledge not driven low");

   a_ptr_sat: assert property (@(posedge clock_in) disable iff (!rstn_in)
      q.ptr[8] |-> q.ptr == PTR_SAT)
      else $error("pointer ran past saturation");

   a_word_pulse: assert property (@(posedge clock_in) disable iff (!rstn_in)
      wr_valid_out |=> !wr_valid_out)
      else $error("word strobe longer than one cycle");

   a_bit_bound: assert property (@(posedge clock_in) disable iff (!rstn_in)
      q.bitcnt <= BYTE_BITS)
      else $error("bit counter beyond one byte");

   a_read_step: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (q.fsm == S_RDATA && ev.scl_fall && q.bitcnt == BYTE_BITS && !q.ptr[8] && !ev.start && !ev.stop)
      |=> q.ptr == $past(q.ptr) + 9'h001)
      else $error("pointer did not step after returned byte");

   a_restart_drop: assert property (@(posedge clock_in) disable iff (!rstn_in)
      (ev.start && !ev.stop) |=> q.fsm == S_ADDR && !q.msb_ok)
      else $error("restart kept a half-written register");
endmodule

// File: verilog/twras_pkg.sv
// Purpose: shared constants and types of the two-wire register access slave
// Assumes: 8-bit register pointer, sixteen-bit registers split over even/odd bytes
// Notes: all offsets, codes and counts of the block live here
package twras_pkg;
   // fixed seven-bit target address, 6Ch write / 6Dh read on the wire
   localparam logic [6:0] TGT_ADDR = 7'h36;
   // last byte location that accepts writes
   localparam logic [8:0] WR_TOP = 9'h04F;
   // pointer value once a read has run past the top of the map
   localparam logic [8:0] PTR_SAT = 9'h100;
   localparam logic [8:0] PTR_STEP = 9'h001;
   // byte returned beyond the top of the map
   localparam logic [7:0] FILL_BYTE = 8'hFF;
   // bits per byte on the link
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   // register pairs below the write limit, one writable flag each
   localparam int PAIR_COUNT = 40;
   // pairs 0..3 read-only by default
   localparam logic [39:0] WRITABLE_DEF = 40'hFF_FFFF_FFF0;
   localparam int SYNC_STAGES = 3;

   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_ADDR = 4'h1,
      S_AACK = 4'h2,
      S_PTR = 4'h3,
      S_PACK = 4'h4,
      S_WDATA = 4'h5,
      S_WACK = 4'h6,
      S_RDATA = 4'h7,
      S_RACK = 4'h8
   } twras_fsm_e;

   typedef struct packed {
      twras_fsm_e fsm;
      logic [3:0] bitcnt;
      logic [7:0] shift;
      logic rd_dir;
      logic [8:0] ptr;
      logic [8:0] pend_addr;
      logic [7:0] msb_byte;
      logic [7:0] msb_addr;
      logic msb_ok;
      logic oe_n;
      logic wr_valid;
      logic [7:0] wr_addr;
      logic [15:0] wr_data;
   } twras_state_s;

   typedef struct packed {
      logic [2:0] scl_s;
      logic [2:0] sda_s;
      logic scl_f;
      logic sda_f;
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
   } twras_sync_s;
endpackage

// File: verilog/twras_bus_if.sv
// Purpose: carries the filtered data level and bus events between sampler and engine
// Assumes: one clock domain, events are single-cycle pulses
// Notes: the sampler drives, the engine listens
`timescale 1ns/1ps
interface twras_bus_if;
   logic sda;
   logic scl_rise;
   logic scl_fall;
   logic start;
   logic stop;
   modport src (output sda, scl_rise, scl_fall, start, stop);
   modport dst (input sda, scl_rise, scl_fall, start, stop);
endinterface

// File: verilog/twras_line_sync.sv
// Purpose: brings serial clock and data into the core clock, finds edges and conditions
// Assumes: core clock well above the serial clock rate
// Notes: a level counts once the second and third stages agree
`timescale 1ns/1ps
module twras_line_sync (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic scl_in,
   input wire logic sda_in,
   twras_bus_if.src ev
);
   import twras_pkg::*;
   twras_sync_s q, n;

   // next state: shift chains, glitch filter, edge and condition decode
   always_comb begin
      n = q;
      n.scl_s = {q.scl_s[1:0], scl_in};
      n.sda_s = {q.sda_s[1:0], sda_in};
      // first stage feeds only the second; filter looks at stages two and three
      if (q.scl_s[1] == q.scl_s[2]) begin
         n.scl_f = q.scl_s[2];
      end
      if (q.sda_s[1] == q.sda_s[2]) begin
         n.sda_f = q.sda_s[2];
      end
      n.scl_rise = n.scl_f & ~q.scl_f;
      n.scl_fall = ~n.scl_f & q.scl_f;
      // data moving while clock stays high marks start or stop
      n.start = q.scl_f & n.scl_f & q.sda_f & ~n.sda_f;
      n.stop = q.scl_f & n.scl_f & ~q.sda_f & n.sda_f;
   end

   // idle bus reads high on both lines
   always_ff @(posedge clock_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '{scl_s: 3'h7, sda_s: 3'h7, scl_f: 1'b1, sda_f: 1'b1, default: 1'b0};
      end else begin
         q <= n;
      end
   end

   assign ev.sda = q.sda_f;
   assign ev.scl_rise = q.scl_rise;
   assign ev.scl_fall = q.scl_fall;
   assign ev.start = q.start;
   assign ev.stop = q.stop;
endmodule

// File: test/twras_master_model.sv
// Purpose: behavioural two-wire bus master driving the serial pins
// Assumes: open-drain data line with pull-up resolved by the bench
// Notes: serial clock stands high outside frames; tasks are called by the bench
`timescale 1ns/1ps
module twras_master_model #(
   parameter time PERIOD = 80ns,
   parameter time HIGH = 30ns
) (
   output logic scl_out,
   output logic sda_low_out,
   input wire logic sda_line_in
);
   // idle bus: clock high, data released
   initial begin
      scl_out = 1'b1;
      sda_low_out = 1'b0;
   end
   // start framing, also repeated start
   // long low phase: the device answers about 45 ns after a clock fall
   task automatic start_c();
      #(10ns);
      sda_low_out = 1'b0;
      #(PERIOD - HIGH - 10ns);
      scl_out = 1'b1;
      #(HIGH + 10ns);
      sda_low_out = 1'b1;
      #(HIGH + 10ns);
      scl_out = 1'b0;
   endtask
   task automatic stop_c();
      #(10ns);
      sda_low_out = 1'b1;
      #(PERIOD - HIGH - 10ns);
      scl_out = 1'b1;
      #(HIGH + 10ns);
      sda_low_out = 1'b0;
      #(HIGH + 10ns);
   endtask
   // master drives data while clock low, sampled at high
   task automatic bit_c(input logic b, output logic s);
      #(10ns);
      sda_low_out = !b;
      #(PERIOD - HIGH - 10ns);
      scl_out = 1'b1;
      #(HIGH);
      // sample at the end of the high phase, then drop the clock
      s = sda_line_in;
      scl_out = 1'b0;
   endtask
   // most significant bit first; clean flags a foreign driver
   task automatic send_bits(input logic [7:0] b, input int n, output logic clean);
      logic s;
      clean = 1'b1;
      for (int i = 7; i > 7 - n; i--) begin
         bit_c(b[i], s);
         clean &= (s === b[i]);
      end
   endtask
   // next byte follows the acknowledge with no gap
   task automatic send_byte(input logic [7:0] b, output logic ack, output logic clean);
      logic s;
      send_bits(b, 8, clean);
      bit_c(1'b1, s);
      ack = (s === 1'b0);
   endtask
   task automatic recv_byte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_c(1'b1, b[i]);
      end
      bit_c(!more, s);
   endtask
endmodule

// File: test/twras_slave_bench.sv
// Purpose: self-checking bench of the two-wire register access slave
// Assumes: byte storage modelled here, read data combinational from rd_addr_out
// Notes: serial clock period 80 ns, 50 ns low so the filtered answer lands before the rise
`timescale 1ns/1ps
module twras_slave_bench;
   import twras_pkg::*;
   logic clock_in = 1'b0;
   logic rstn_in = 1'b0;
   logic m_scl, m_low, sda_line, sda_out, sda_oe_n_out, wr_valid_out;
   logic [7:0] rd_addr_out, wr_addr_out, rd_data_in;
   logic [15:0] wr_data_out;
   logic [7:0] mem [0:255];
   logic [23:0] got[$], exp_q[$];
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;

   initial forever #5 clock_in = ~clock_in;
   // wired-and of both parties with pull-up
   assign sda_line = (m_low || (sda_oe_n_out === 1'b0 && sda_out === 1'b0)) ? 1'b0 : 1'b1;
   assign rd_data_in = mem[rd_addr_out];

   twras_master_model u_twras_master_model (.scl_out(m_scl), .sda_low_out(m_low), .sda_line_in(sda_line));
   twras_slave u_twras_slave (.clock_in(clock_in), .rstn_in(rstn_in), .scl_in(m_scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .rd_addr_out(rd_addr_out), .rd_data_in(rd_data_in),
      .wr_valid_out(wr_valid_out), .wr_addr_out(wr_addr_out), .wr_data_out(wr_data_out));

   // capture word writes; cut a hang short
   always @(negedge clock_in) begin
      if (wr_valid_out === 1'b1) got.push_back({wr_addr_out, wr_data_out});
      cycles++;
      if (cycles == 90000) begin
         fails++;
         stop_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
      samples_checked++;
      if (seen !== exp) begin
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
         fails++;
      end
   endtask

   task automatic stop_test();
      if (fails == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // even location of a word that accepts writes
   function automatic logic wok(input int loc);
      return loc <= int'(WR_TOP) && WRITABLE_DEF[loc / 2] === 1'b1;
   endfunction

   // write: n whole bytes, then optionally a byte cut after some bits
   task automatic wtxn(input logic [7:0] a8, input logic [7:0] ptr, input int n, input int cut);
      logic [7:0] d, prev;
      logic ack, cl, m;
      int loc;
      m = (a8 == 8'h6C);
      got.delete();
      u_twras_master_model.start_c();
      u_twras_master_model.send_byte(a8, ack, cl);
      check(ack, m, "address ack");
      u_twras_master_model.send_byte(ptr, ack, cl);
      check(ack, m, "pointer ack");
      for (int i = 0; i < n; i++) begin
         d = $urandom;
         u_twras_master_model.send_byte(d, ack, cl);
         check({ack, cl}, {m, 1'b1}, "data ack");
         loc = int'(ptr) + i;
         if (m && i > 0 && loc % 2 == 1 && wok(loc - 1)) exp_q.push_back({8'(loc - 1), prev, d});
         prev = d;
      end
      if (cut > 0) u_twras_master_model.send_bits(d, cut, cl);
      u_twras_master_model.stop_c();
      repeat (20) @(negedge clock_in);
      check(got.size(), exp_q.size(), "word count");
      while (exp_q.size() > 0 && got.size() > 0) check(got.pop_front(), exp_q.pop_front(), "word");
      exp_q.delete();
      check(sda_oe_n_out, 1'b1, "line released");
   endtask

   // read: pointer write, repeated start, n bytes, last one not acknowledged
   task automatic rtxn(input logic [7:0] ptr, input int n);
      logic [7:0] d;
      logic ack, cl;
      int loc;
      u_twras_master_model.start_c();
      u_twras_master_model.send_byte(8'h6C, ack, cl);
      u_twras_master_model.send_byte(ptr, ack, cl);
      u_twras_master_model.start_c();
      u_twras_master_model.send_byte(8'h6D, ack, cl);
      check(ack, 1'b1, "read address ack");
      for (int i = 0; i < n; i++) begin
         u_twras_master_model.recv_byte(i < n - 1, d);
         loc = int'(ptr) + i;
         check(d, (loc > 255) ? FILL_BYTE : mem[loc], "read byte");
      end
      repeat (4) @(negedge clock_in);
      check(sda_oe_n_out, 1'b1, "released after nack");
      u_twras_master_model.stop_c();
      repeat (8) @(negedge clock_in);
   endtask

   initial begin
      logic [7:0] fa;
      void'($urandom(32'h8041));
      for (int i = 0; i < 256; i++) mem[i] = $urandom;
      repeat (20) @(negedge clock_in);
      rstn_in = 1'b1;
      repeat (5) @(negedge clock_in);
      wtxn(8'h6C, 8'h10, 2, 0);
      wtxn(8'h6C, 8'h20, 6, 0);
      wtxn(8'h6C, 8'h11, 3, 0);
      wtxn(8'h6C, 8'h02, 2, 0);
      wtxn(8'h6C, 8'h4C, 6, 0);
      wtxn(8'h6C, 8'h30, 1, 0);
      wtxn(8'h6C, 8'h32, 1, 4);
      wtxn(8'h6C, 8'h34, 2, 6);
      // foreign addresses are never acknowledged
      for (int i = 0; i < 3; i++) begin
         fa = $urandom;
         if (fa[7:1] == TGT_ADDR) fa[7] = ~fa[7];
         wtxn(fa, 8'h10, 2, 0);
      end
      for (int i = 0; i < 10; i++) wtxn(8'h6C, 8'($urandom_range(0, 'h4F)), $urandom_range(1, 5), 0);
      rtxn(8'h00, 2);
      rtxn(8'hFE, 4);
      // whole registers only: even start, even byte count
      for (int i = 0; i < 5; i++) rtxn(8'($urandom) & 8'hFE, 2 * $urandom_range(1, 2));
      stop_test();
   end
endmodule
